// file: core/fpg_range_decode.sv
module fpg_range_decode (
  input  wire logic [7:0]              prog_guard, // program_array_guard
  input  wire logic [7:0]              data_guard, // data_array_guard
  input  wire logic                    is_data,    // target is data array
  input  wire logic [fpg_pkg::P_AW-1:0] addr,      // target address
  output logic                         sect_prot,  // target sector shielded
  output logic                         blk_prot    // target block shielded
);
  import fpg_pkg::*;

  logic [P_AW-1:0] hi_size;
  logic [P_AW-1:0] lo_size;
  logic [P_AW-1:0] lo_end;
  logic [D_AW:0]   d_lim;
  logic            in_hi;
  logic            in_lo;
  logic            p_sect;
  logic            p_blk;
  logic            d_sect;
  logic            d_blk;

  assign hi_size = HI_UNIT << prog_guard[PG_HS_HI:PG_HS_LO];
  assign lo_size = LO_UNIT << prog_guard[PG_LS_HI:PG_LS_LO];
  assign lo_end  = P_LO_BASE + lo_size;

  assign in_hi = !prog_guard[PG_HDIS] && (addr > P_TOP - hi_size);
  assign in_lo = !prog_guard[PG_LDIS] && (addr >= P_LO_BASE)
                 && (addr < lo_end);

  // open set: ranges are shielded; open clear: ranges are the only holes
  assign p_sect = prog_guard[PG_OPEN] ? (in_hi || in_lo)
                                      : !(in_hi || in_lo);
  // single block: with open clear some sector is always shielded
  assign p_blk = prog_guard[PG_OPEN] ?
                 (!prog_guard[PG_HDIS] || !prog_guard[PG_LDIS]) : 1'b1;

  assign d_lim  = (D_AW + 1)'({1'b0, data_guard[DG_SPAN_HI:0]} + 5'h01)
                  << SPAN_SHIFT;
  assign d_sect = !data_guard[DG_OPEN]
                  && ({1'b0, addr[D_AW-1:0]} < d_lim);
  assign d_blk  = !data_guard[DG_OPEN];

  assign sect_prot = is_data ? d_sect : p_sect;
  assign blk_prot  = is_data ? d_blk : p_blk;
endmodule

// file: core/fpg_top.sv
// What this block does
// - reset load copies program guard byte
// - double fault at load forces full protection
// - illegal program guard writes leave register unchanged
// - only listed scenario transitions are accepted
// - reads return the scenario now in force
// - shielded program or erase refused, flags violation
// - block erase refused if any sector shielded
// - open bit flips range meaning
// - upper range off bit governs top region
// - upper size writable only while range off
// - lower range off bit governs low region
// - lower size writable only while range off
// - data guard marks shielded data sectors
// - data guard writes may only add protection
// - data span ignored while data open set
// - reset load copies data guard byte
module fpg_top (
  input  wire logic                       clock,         // system clock
  input  wire logic                       rst,           // async reset, high
  input  wire logic [fpg_pkg::AXI_AW-1:0] s_axi_awaddr,  // write address
  input  wire logic                       s_axi_awvalid, // write addr valid
  output logic                            s_axi_awready, // write addr ready
  input  wire logic [31:0]                s_axi_wdata,   // write data
  input  wire logic [3:0]                 s_axi_wstrb,   // write strobes
  input  wire logic                       s_axi_wvalid,  // write data valid
  output logic                            s_axi_wready,  // write data ready
  output logic [1:0]                      s_axi_bresp,   // write response
  output logic                            s_axi_bvalid,  // response valid
  input  wire logic                       s_axi_bready,  // response ready
  input  wire logic [fpg_pkg::AXI_AW-1:0] s_axi_araddr,  // read address
  input  wire logic                       s_axi_arvalid, // read addr valid
  output logic                            s_axi_arready, // read addr ready
  output logic [31:0]                     s_axi_rdata,   // read data
  output logic [1:0]                      s_axi_rresp,   // read response
  output logic                            s_axi_rvalid,  // read data valid
  input  wire logic                       s_axi_rready,  // read data ready
  input  wire logic                       cfg_load,      // config bytes valid
  input  wire logic [7:0]                 cfg_prog_byte, // program guard byte
  input  wire logic [7:0]                 cfg_data_byte, // data guard byte
  input  wire logic                       cfg_dbl_fault, // double-bit fault
  input  wire logic                       op_valid,      // operation request
  output logic                            op_ready,      // request may be taken
  input  wire logic [1:0]                 op_kind,       // program or erase
  input  wire logic                       op_is_data,    // data array target
  input  wire logic [fpg_pkg::P_AW-1:0]   op_addr,       // target address
  output logic                            op_accept,     // operation allowed
  output logic                            op_refuse      // operation refused
);
  import fpg_pkg::*;

  logic              aw_full_q;
  logic              w_full_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rd_word;
  logic [7:0]        stat;
  logic [7:0]        prog_q;
  logic [7:0]        prog_d;
  logic [7:0]        data_q;
  logic [7:0]        data_d;
  logic              loaded_q;
  logic              fault_q;
  logic              viol_q;
  logic              op_accept_q;
  logic              op_refuse_q;
  logic              wr_go;
  logic [1:0]        wr_sel;
  logic [1:0]        rd_sel;
  logic              prog_wr;
  logic              prog_ok;
  logic              data_wr;
  logic              data_ok;
  logic              stat_clr;
  logic              load_go;
  logic              op_take;
  logic              op_prot;
  logic              sect_prot;
  logic              blk_prot;
  logic [1:0]        hs_cur;
  logic [1:0]        ls_cur;
  logic [3:0]        span_cur;

  // write channel: address and data captured independently
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign wr_go         = aw_full_q && w_full_q && !bvalid_q;
  assign wr_sel        = reg_sel(awaddr_q);
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel
  assign s_axi_arready = !rvalid_q;
  assign rd_sel        = reg_sel(s_axi_araddr);
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_comb begin
    stat            = 8'h00;
    stat[ST_LOADED] = loaded_q;
    stat[ST_FAULT]  = fault_q;
    stat[ST_VIOL]   = viol_q;
  end

  always_comb begin
    case (rd_sel)
      SEL_PROG: rd_word = {24'h00_0000, prog_q};
      SEL_DATA: rd_word = {24'h00_0000, data_q};
      SEL_STAT: rd_word = {24'h00_0000, stat};
      default:  rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_q  <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // reset-sequence load; guards hold full protection until it arrives
  assign load_go = cfg_load && !loaded_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loaded_q <= 1'b0;
      fault_q  <= 1'b0;
    end else if (load_go) begin
      loaded_q <= 1'b1;
      fault_q  <= cfg_dbl_fault;
    end
  end

  // candidate value: reserved bit is not writable, sizes gated
  always_comb begin
    prog_d         = wdata_q[7:0];
    prog_d[PG_RSV] = prog_q[PG_RSV];
    if (!prog_q[PG_HDIS]) begin
      prog_d[PG_HS_HI:PG_HS_LO] = prog_q[PG_HS_HI:PG_HS_LO];
    end
    if (!prog_q[PG_LDIS]) begin
      prog_d[PG_LS_HI:PG_LS_LO] = prog_q[PG_LS_HI:PG_LS_LO];
    end
  end

  assign prog_wr = wr_go && (wr_sel == SEL_PROG) && wstrb_q[0] && loaded_q;
  assign prog_ok = move_ok(scen(prog_q), scen(prog_d));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prog_q <= PG_FULL;
    end else if (load_go) begin
      prog_q <= cfg_dbl_fault ? PG_FULL : cfg_prog_byte;
    end else if (prog_wr && prog_ok) begin
      prog_q <= prog_d;
    end
  end

  assign data_d  = wdata_q[7:0] & DG_MASK;
  assign data_wr = wr_go && (wr_sel == SEL_DATA) && wstrb_q[0] && loaded_q;
  assign data_ok = (data_d[DG_SPAN_HI:0] >= data_q[DG_SPAN_HI:0])
                   && !(data_d[DG_OPEN] && !data_q[DG_OPEN]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_q <= DG_FULL;
    end else if (load_go) begin
      data_q <= cfg_dbl_fault ? DG_FULL : (cfg_data_byte & DG_MASK);
    end else if (data_wr && data_ok) begin
      data_q <= data_d;
    end
  end

  // operation check
  fpg_range_decode u_dec (
    .prog_guard (prog_q),
    .data_guard (data_q),
    .is_data    (op_is_data),
    .addr       (op_addr),
    .sect_prot  (sect_prot),
    .blk_prot   (blk_prot)
  );

  assign op_ready = loaded_q;
  assign op_take  = op_valid && op_ready;
  assign op_prot  = (op_kind == OP_BLK_ERASE) ? blk_prot : sect_prot;
  assign op_accept = op_accept_q;
  assign op_refuse = op_refuse_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op_accept_q <= 1'b0;
      op_refuse_q <= 1'b0;
    end else begin
      op_accept_q <= op_take && !op_prot;
      op_refuse_q <= op_take && op_prot;
    end
  end

  // sticky; a new violation beats a same-cycle clear
  assign stat_clr = wr_go && (wr_sel == SEL_STAT) && wstrb_q[0]
                    && wdata_q[ST_VIOL];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      viol_q <= 1'b0;
    end else if (op_take && op_prot) begin
      viol_q <= 1'b1;
    end else if (stat_clr) begin
      viol_q <= 1'b0;
    end
  end

  assign hs_cur   = prog_q[PG_HS_HI:PG_HS_LO];
  assign ls_cur   = prog_q[PG_LS_HI:PG_LS_LO];
  assign span_cur = data_q[DG_SPAN_HI:0];

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_bad_move;
    prog_wr && !prog_ok;
  endsequence

  sequence s_refused_op;
    op_take && op_prot;
  endsequence

  a_load_copy: assert property (
    load_go && !cfg_dbl_fault |=> prog_q == $past(cfg_prog_byte))
    else $error("program guard not loaded from config byte");

  a_fault_full: assert property (
    load_go && cfg_dbl_fault |=> prog_q == PG_FULL && data_q == DG_FULL)
    else $error("double fault did not force full protection");

  a_bad_move_kept: assert property (
    s_bad_move |=> $stable(prog_q))
    else $error("illegal guard write changed the register");

  a_move_legal: assert property (
    $past(loaded_q) && $changed(prog_q)
    |-> move_ok(scen($past(prog_q)), scen(prog_q)))
    else $error("guard moved to a forbidden scenario");

  a_read_current: assert property (
    s_axi_arvalid && s_axi_arready && rd_sel == SEL_PROG
    |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(prog_q))
    else $error("guard read does not show current value");

  a_viol_flag: assert property (
    s_refused_op |=> viol_q && op_refuse && !op_accept)
    else $error("refused operation did not raise violation");

  a_block_erase: assert property (
    op_take && op_kind == OP_BLK_ERASE && blk_prot |=> op_refuse && viol_q)
    else $error("block erase allowed over shielded sector");

  a_hsize_held: assert property (
    prog_wr && !prog_q[PG_HDIS] |=> hs_cur == $past(hs_cur))
    else $error("upper size changed while range enabled");

  a_lsize_held: assert property (
    prog_wr && !prog_q[PG_LDIS] |=> ls_cur == $past(ls_cur))
    else $error("lower size changed while range enabled");

  a_data_grow: assert property (
    $past(loaded_q) && $changed(data_q)
    |-> span_cur >= $past(span_cur)
        && !(data_q[DG_OPEN] && !$past(data_q[DG_OPEN])))
    else $error("data guard lost protection");

  a_refuse_flag: assert property (
    op_refuse |-> viol_q)
    else $error("refusal without violation flag");

  a_one_answer: assert property (
    op_take |=> op_accept ^ op_refuse)
    else $error("operation did not get exactly one answer");

  a_full_shield: assert property (
    !op_is_data && scen(prog_q) == 3'h3 |-> sect_prot && blk_prot)
    else $error("full scenario left a program hole");

  a_none_shield: assert property (
    !op_is_data && scen(prog_q) == 3'h7 |-> !sect_prot && !blk_prot)
    else $error("open scenario shielded program array");

  a_data_open: assert property (
    op_is_data && data_q[DG_OPEN] |-> !sect_prot && !blk_prot)
    else $error("data span used while data guard open");

  a_load_data: assert property (
    load_go && !cfg_dbl_fault
    |=> data_q == ($past(cfg_data_byte) & DG_MASK))
    else $error("data guard not loaded from config byte");

  a_lower_hole: assert property (
    !op_is_data && !prog_q[PG_OPEN] && !prog_q[PG_LDIS]
    && op_addr == P_LO_BASE |-> !sect_prot)
    else $error("lower range base not left open");
endmodule

// file: shared/fpg_pkg.sv
package fpg_pkg;
  // register bus map
  localparam int               AXI_AW      = 4;
  localparam logic [AXI_AW-1:0] OFS_PROG   = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_DATA   = 4'h4;
  localparam logic [AXI_AW-1:0] OFS_STAT   = 4'h8;
  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;
  localparam logic [1:0]       SEL_PROG    = 2'h0;
  localparam logic [1:0]       SEL_DATA    = 2'h1;
  localparam logic [1:0]       SEL_STAT    = 2'h2;
  localparam logic [1:0]       SEL_NONE    = 2'h3;

  // program_array_guard fields
  localparam int         PG_OPEN  = 7;
  localparam int         PG_RSV   = 6;
  localparam int         PG_HDIS  = 5;
  localparam int         PG_HS_HI = 4;
  localparam int         PG_HS_LO = 3;
  localparam int         PG_LDIS  = 2;
  localparam int         PG_LS_HI = 1;
  localparam int         PG_LS_LO = 0;
  localparam logic [7:0] PG_FULL  = 8'h7F;

  // data_array_guard fields
  localparam int         DG_OPEN    = 7;
  localparam int         DG_SPAN_HI = 3;
  localparam logic [7:0] DG_MASK    = 8'h8F;
  localparam logic [7:0] DG_FULL    = 8'h0F;

  // nvm_status_reg fields
  localparam int ST_LOADED = 0;
  localparam int ST_FAULT  = 1;
  localparam int ST_VIOL   = 4;

  // array geometry and range sizes
  localparam int              P_AW       = 18;
  localparam int              D_AW       = 12;
  localparam logic [P_AW-1:0] P_TOP      = 18'h3_FFFF;
  localparam logic [P_AW-1:0] P_LO_BASE  = 18'h3_8000;
  localparam logic [P_AW-1:0] HI_UNIT    = 18'h0_0800;
  localparam logic [P_AW-1:0] LO_UNIT    = 18'h0_0400;
  localparam int              SPAN_SHIFT = 8;

  // operation kinds
  localparam logic [1:0] OP_PROG       = 2'h0;
  localparam logic [1:0] OP_SECT_ERASE = 2'h1;
  localparam logic [1:0] OP_BLK_ERASE  = 2'h2;

  function automatic logic [1:0] reg_sel(input logic [AXI_AW-1:0] a);
    case (a)
      OFS_PROG: return SEL_PROG;
      OFS_DATA: return SEL_DATA;
      OFS_STAT: return SEL_STAT;
      default:  return SEL_NONE;
    endcase
  endfunction

  function automatic logic [2:0] scen(input logic [7:0] g);
    return {g[PG_OPEN], g[PG_HDIS], g[PG_LDIS]};
  endfunction

  function automatic logic move_ok(input logic [2:0] f, input logic [2:0] t);
    logic [7:0] m;
    m = 8'h00;
    case (f)
      3'h0: m = 8'h0F;
      3'h1: m = 8'h0A;
      3'h2: m = 8'h0C;
      3'h3: m = 8'h08;
      3'h4: m = 8'h18;
      3'h5: m = 8'h3C;
      3'h6: m = 8'h5A;
      default: m = 8'hFF;
    endcase
    return m[t];
  endfunction
endpackage

// file: testbench/fpg_top_tb.sv
module fpg_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fpg_pkg::*;

  logic              clock, rst, awv, awr, wv, wr_o, bv, br;
  logic              arv, arr, rv, rr, ld, flt, opv, oprdy, isd;
  logic              acc, refu;
  logic [AXI_AW-1:0] awa, ara;
  logic [31:0]       wd, rdat;
  logic [3:0]        ws;
  logic [1:0]        bresp, rresp, kind;
  logic [7:0]        pb, db;
  logic [P_AW-1:0]   opa;
  int                num_errors, n_compared;
  // allowed targets per source scenario, bit t set when t is reachable
  logic [7:0]        ok_tab [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                    8'h18, 8'h3C, 8'h5A, 8'hFF};

  fpg_top fpg_top_i (
    .clock(clock), .rst(rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_o), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .cfg_load(ld),
    .cfg_prog_byte(pb), .cfg_data_byte(db), .cfg_dbl_fault(flt),
    .op_valid(opv), .op_ready(oprdy), .op_kind(kind),
    .op_is_data(isd), .op_addr(opa), .op_accept(acc),
    .op_refuse(refu)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic close_out;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic hang;
    num_errors++;
    $display("timeout at %0t", $time);
    close_out();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // program guard byte for a scenario {open, upper off, lower off}
  function automatic logic [7:0] sb(input logic [2:0] s);
    return {s[2], 1'b0, s[1], 2'b00, s[0], 2'b00};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    bit done;
    @(posedge clock);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    done = 0;
    for (int n = 0; n < 30 && !done; n++) begin
      @(posedge clock);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_o) wv <= 1'b0;
      if (bv && br) begin
        br <= 1'b0;
        done = 1;
        check({30'h0, bresp}, {30'h0, er});
      end
    end
    if (!done) hang();
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    done = 0;
    for (int n = 0; n < 30 && !done; n++) begin
      @(posedge clock);
      if (arv && arr) arv <= 1'b0;
      if (rv && rr) begin
        rr <= 1'b0;
        d = rdat;
        r = rresp;
        done = 1;
      end
    end
    if (!done) hang();
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, {24'h0, exp});
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // reset, then one configuration load with the given bytes
  task automatic boot(input logic [7:0] p, input logic [7:0] d,
                      input logic f);
    @(posedge clock);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    pb <= p;
    db <= d;
    flt <= f;
    ld <= 1'b1;
    @(posedge clock);
    ld <= 1'b0;
    flt <= 1'b0;
  endtask

  task automatic op(input logic [1:0] k, input logic dat,
                    input logic [P_AW-1:0] a, input logic exp_ref);
    bit done;
    @(posedge clock);
    kind <= k;
    isd <= dat;
    opa <= a;
    opv <= 1'b1;
    done = 0;
    for (int n = 0; n < 30 && !done; n++) begin
      @(posedge clock);
      if (oprdy) done = 1;
    end
    if (!done) hang();
    opv <= 1'b0;
    @(posedge clock);
    check({30'h0, acc, refu}, {30'h0, !exp_ref, exp_ref});
  endtask

  task automatic t_reset;
    check({31'h0, oprdy}, 32'h0);
    rdchk(OFS_PROG, PG_FULL);
    wr(OFS_PROG, 8'h80, RESP_OKAY);
    rdchk(OFS_PROG, PG_FULL);
    rdchk(OFS_DATA, DG_FULL);
  endtask

  task automatic t_load;
    boot(8'hA4, 8'h81, 1'b0);
    rdchk(OFS_PROG, 8'hA4);
    rdchk(OFS_DATA, 8'h81);
    rdchk(OFS_STAT, 8'h01);
    @(posedge clock);
    pb <= 8'h00;
    ld <= 1'b1;
    @(posedge clock);
    ld <= 1'b0;
    rdchk(OFS_PROG, 8'hA4);
    boot(8'hA4, 8'h81, 1'b1);
    rdchk(OFS_PROG, PG_FULL);
    rdchk(OFS_DATA, DG_FULL);
    rdchk(OFS_STAT, 8'h03);
  endtask

  task automatic t_moves;
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        boot(sb(3'(f)), 8'h80, 1'b0);
        wr(OFS_PROG, sb(3'(t)), RESP_OKAY);
        rdchk(OFS_PROG, ok_tab[f][t] ? sb(3'(t)) : sb(3'(f)));
      end
    end
  endtask

  task automatic t_sizes;
    boot(8'hA4, 8'h80, 1'b0);
    wr(OFS_PROG, 8'hBF, RESP_OKAY);
    rdchk(OFS_PROG, 8'hBF);
    boot(8'h00, 8'h80, 1'b0);
    wr(OFS_PROG, 8'h1B, RESP_OKAY);
    rdchk(OFS_PROG, 8'h00);
  endtask

  task automatic t_ops;
    boot(8'hA4, 8'h80, 1'b0);
    op(OP_PROG, 1'b0, P_TOP, 1'b0);
    op(OP_BLK_ERASE, 1'b0, P_LO_BASE, 1'b0);
    boot(8'h84, 8'h8F, 1'b0);
    op(OP_PROG, 1'b0, P_TOP, 1'b1);
    op(OP_SECT_ERASE, 1'b0, P_TOP - HI_UNIT, 1'b0);
    op(OP_BLK_ERASE, 1'b0, P_LO_BASE, 1'b1);
    op(OP_PROG, 1'b1, 18'h0, 1'b0);
    rdchk(OFS_STAT, 8'h11);
    wr(OFS_STAT, 8'h10, RESP_OKAY);
    rdchk(OFS_STAT, 8'h01);
    boot(8'h20, 8'h01, 1'b0);
    op(OP_PROG, 1'b0, P_LO_BASE, 1'b0);
    op(OP_PROG, 1'b0, P_LO_BASE + LO_UNIT, 1'b1);
    op(OP_PROG, 1'b1, 18'h1FF, 1'b1);
    op(OP_SECT_ERASE, 1'b1, 18'h200, 1'b0);
  endtask

  task automatic t_data;
    logic [7:0] wv_t [4] = '{8'h82, 8'h01, 8'h03, 8'h83};
    logic [7:0] ex_t [4] = '{8'h82, 8'h82, 8'h03, 8'h03};
    boot(8'hA4, 8'h81, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DATA, wv_t[i], RESP_OKAY);
      rdchk(OFS_DATA, ex_t[i]);
    end
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    wr(4'hC, 8'hFF, RESP_SLVERR);
    rd(4'hC, d, r);
    check(d, 32'h0000_0000);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    rdchk(OFS_PROG, 8'hA4);
  endtask

  initial begin
    rst = 1'b1;
    {awv, wv, br, arv, rr, ld, flt, opv, isd} = '0;
    awa = '0;
    ara = '0;
    wd = '0;
    ws = 4'hF;
    pb = '0;
    db = '0;
    kind = '0;
    opa = '0;
    num_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_load();
    t_moves();
    t_sizes();
    t_ops();
    t_data();
    t_unmapped();
    close_out();
  end
endmodule
